/* File: shared/charger_pkg.sv */
package charger_pkg;
   localparam logic [6:0] DEV_ADDR       = 7'h48;
   localparam logic [7:0] REG_STATUS     = 8'h00;
   localparam logic [7:0] REG_CFG1       = 8'h02;
   localparam logic [7:0] REG_CFG3       = 8'h04;
   localparam logic [7:0] REG_CFG_EN     = 8'h11;
   localparam logic [7:0] REG_EE_CTRL    = 8'h12;
   localparam int         ST_OV_BIT      = 7;
   localparam int         ST_HOT_BIT     = 3;
   localparam int         ST_UV_BIT      = 1;
   localparam logic [7:0] FAULT_MASK     = 8'h88;
   localparam logic [7:0] STATUS_RST     = 8'h00;
   localparam logic [7:0] CFG1_RST       = 8'h00;
   localparam logic [7:0] CFG3_RST       = 8'h00;
   localparam logic [7:0] CFG_EN_RST     = 8'h00;
   localparam logic [7:0] EE_CTRL_RST    = 8'h00;
   localparam logic [7:0] CFG1_WMASK     = 8'h38;
   localparam logic [7:0] CFG3_WMASK     = 8'hf0;
   localparam logic [7:0] CFG_EN_WMASK   = 8'h01;
   localparam int         CFG_EN_BIT     = 0;
   typedef enum logic [1:0] {
      CHG_OFF  = 2'b00,
      CHG_TRACK = 2'b01,
      CHG_CV   = 2'b10,
      CHG_HOT  = 2'b11
   } chg_state_t;
   typedef enum logic [2:0] {
      I2C_IDLE  = 3'b000,
      I2C_RECV  = 3'b001,
      I2C_ACK   = 3'b010,
      I2C_SEND  = 3'b011,
      I2C_MACK  = 3'b100
   } i2c_state_t;
endpackage

/* File: hdl/sync2.sv */
`timescale 1ns/1ns
module sync2
   import charger_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= din;
         stage2_ff <= stage1_ff;
      end
   end
   assign dout = stage2_ff;
endmodule

/* File: hdl/i2c_slave_if.sv */
`timescale 1ns/1ns
module i2c_slave_if
   import charger_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   output logic            wrStrobe,
   output logic [7:0]      wrData,
   output logic            rdStrobe,
   input  wire logic [7:0] rdData
);
   logic       sclS;
   logic       sdaS;
   logic       sclD_ff;
   logic       sdaD_ff;
   i2c_state_t state_ff,  nxt_state;
   logic [7:0] shift_ff,  nxt_shift;
   logic [3:0] bitCnt_ff, nxt_bitCnt;
   logic       isAddr_ff, nxt_isAddr;
   logic       isRead_ff, nxt_isRead;
   logic       drive_ff,  nxt_drive;
   logic       wrStb_ff,  nxt_wrStb;
   logic       rdStb_ff,  nxt_rdStb;
   logic [7:0] wrDat_ff,  nxt_wrDat;
   logic       sclRise;
   logic       sclFall;
   logic       startC;
   logic       stopC;

   sync2 #(.WIDTH(2)) u_sync (
      .clk  (clk),
      .srst (srst),
      .din  ({sclIn, sdaIn}),
      .dout ({sclS, sdaS})
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         sclD_ff <= 1'b1;
         sdaD_ff <= 1'b1;
      end else begin
         sclD_ff <= sclS;
         sdaD_ff <= sdaS;
      end
   end

   assign sclRise = sclS & ~sclD_ff;
   assign sclFall = ~sclS & sclD_ff;
   assign startC  = sclS & sclD_ff & sdaD_ff & ~sdaS;
   assign stopC   = sclS & sclD_ff & ~sdaD_ff & sdaS;

   always_comb begin
      nxt_state  = state_ff;
      nxt_shift  = shift_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_isAddr = isAddr_ff;
      nxt_isRead = isRead_ff;
      nxt_drive  = drive_ff;
      nxt_wrStb  = 1'b0;
      nxt_rdStb  = 1'b0;
      nxt_wrDat  = wrDat_ff;
      if (startC) begin
         nxt_state  = I2C_RECV;
         nxt_bitCnt = 4'h0;
         nxt_isAddr = 1'b1;
         nxt_drive  = 1'b0;
      end else if (stopC) begin
         nxt_state = I2C_IDLE;
         nxt_drive = 1'b0;
      end else begin
         unique case (state_ff)
            I2C_IDLE: begin
               nxt_drive = 1'b0;
            end
            I2C_RECV: begin
               if (sclRise) begin
                  nxt_shift  = {shift_ff[6:0], sdaS};
                  nxt_bitCnt = bitCnt_ff + 4'h1;
               end else if (sclFall && bitCnt_ff == 4'h8) begin
                  nxt_bitCnt = 4'h0;
                  if (isAddr_ff) begin
                     if (shift_ff[7:1] == DEV_ADDR) begin
                        nxt_isRead = shift_ff[0];
                        nxt_drive  = 1'b1;
                        nxt_state  = I2C_ACK;
                     end else begin
                        nxt_state = I2C_IDLE;
                     end
                  end else begin
                     nxt_wrDat = shift_ff;
                     nxt_wrStb = 1'b1;
                     nxt_drive = 1'b1;
                     nxt_state = I2C_ACK;
                  end
               end
            end
            I2C_ACK: begin
               if (sclFall) begin
                  nxt_isAddr = 1'b0;
                  if (isRead_ff && isAddr_ff) begin
                     nxt_shift = rdData;
                     nxt_rdStb = 1'b1;
                     nxt_drive = ~rdData[7];
                     nxt_state = I2C_SEND;
                  end else begin
                     nxt_drive = 1'b0;
                     nxt_state = I2C_RECV;
                  end
               end
            end
            I2C_SEND: begin
               if (sclFall) begin
                  nxt_bitCnt = bitCnt_ff + 4'h1;
                  if (bitCnt_ff == 4'h7) begin
                     nxt_drive = 1'b0;
                     nxt_state = I2C_MACK;
                  end else begin
                     nxt_shift = {shift_ff[6:0], 1'b0};
                     nxt_drive = ~shift_ff[6];
                  end
               end
            end
            I2C_MACK: begin
               if (sclRise) begin
                  nxt_bitCnt = 4'h0;
                  if (sdaS) begin
                     nxt_state = I2C_IDLE;
                  end else begin
                     nxt_state = I2C_ACK;
                     nxt_isAddr = 1'b1;
                  end
               end
            end
            default: begin
               nxt_state = I2C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff  <= I2C_IDLE;
         shift_ff  <= 8'h00;
         bitCnt_ff <= 4'h0;
         isAddr_ff <= 1'b0;
         isRead_ff <= 1'b0;
         drive_ff  <= 1'b0;
         wrStb_ff  <= 1'b0;
         rdStb_ff  <= 1'b0;
         wrDat_ff  <= 8'h00;
      end else begin
         state_ff  <= nxt_state;
         shift_ff  <= nxt_shift;
         bitCnt_ff <= nxt_bitCnt;
         isAddr_ff <= nxt_isAddr;
         isRead_ff <= nxt_isRead;
         drive_ff  <= nxt_drive;
         wrStb_ff  <= nxt_wrStb;
         rdStb_ff  <= nxt_rdStb;
         wrDat_ff  <= nxt_wrDat;
      end
   end

   assign sdaOut   = 1'b0;
   assign sdaOe    = drive_ff;
   assign wrStrobe = wrStb_ff;
   assign wrData   = wrDat_ff;
   assign rdStrobe = rdStb_ff;
endmodule

/* File: hdl/charger_i2c_slave_fault_monitor.sv */
`timescale 1ns/1ns
module charger_i2c_slave_fault_monitor
   import charger_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       enablePin,
   input  wire logic       supplyAboveOn,
   input  wire logic       supplyBelowOff,
   input  wire logic       outAtTerm,
   input  wire logic       outOverVolt,
   input  wire logic       overcurrent_threshold,
   input  wire logic       tempAbove170,
   input  wire logic       tempBelow160,
   input  wire logic       cycleStart,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   output logic            fault_out_n_out,
   output logic            fault_out_n_oe,
   output logic            switchOn,
   output logic            switch_node_out_oe,
   output logic            max_power_tracking,
   output logic            cvRegulate,
   output logic            running,
   output logic [2:0]      termSelect,
   output logic [3:0]      chargeCurrentSel
);
   logic [8:0] pinsS;
   logic       enS;
   logic       uvOnS;
   logic       uvOffS;
   logic       termS;
   logic       ovS;
   logic       ocS;
   logic       hotS;
   logic       coolS;
   logic       cycS;
   logic       wrStrobe;
   logic [7:0] wrData;
   logic       rdStrobe;
   logic [7:0] rdData;
   logic       faultAny;
   logic [1:0] busS;
   logic       sclBusD_ff;
   logic       sdaBusD_ff;
   logic       busStart;

   chg_state_t chg_ff,     nxt_chg;
   logic       run_ff,     nxt_run;
   logic       pwm_ff,     nxt_pwm;
   logic [7:0] status_ff,  nxt_status;
   logic [7:0] cfg1_ff,    nxt_cfg1;
   logic [7:0] cfg3_ff,    nxt_cfg3;
   logic [7:0] cfgEn_ff,   nxt_cfgEn;
   logic [7:0] eeCtrl_ff,  nxt_eeCtrl;
   logic [7:0] ptr_ff,     nxt_ptr;
   logic       ptrNext_ff, nxt_ptrNext;
   logic [7:0] rdData_ff,  nxt_rdData;

   sync2 #(.WIDTH(9)) u_pins (
      .clk  (clk),
      .srst (srst),
      .din  ({enablePin, supplyAboveOn, supplyBelowOff, outAtTerm, outOverVolt,
              overcurrent_threshold, tempAbove170, tempBelow160, cycleStart}),
      .dout (pinsS)
   );
   assign {enS, uvOnS, uvOffS, termS, ovS, ocS, hotS, coolS, cycS} = pinsS;

   i2c_slave_if u_i2c (
      .clk      (clk),
      .srst     (srst),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sdaOut   (sdaOut),
      .sdaOe    (sdaOe),
      .wrStrobe (wrStrobe),
      .wrData   (wrData),
      .rdStrobe (rdStrobe),
      .rdData   (rdData)
   );

   // Start condition seen here too, so every write transfer reloads the pointer
   sync2 #(.WIDTH(2)) u_bus (
      .clk  (clk),
      .srst (srst),
      .din  ({sclIn, sdaIn}),
      .dout (busS)
   );
   always_ff @(posedge clk) begin
      if (srst) begin
         sclBusD_ff <= 1'b1;
         sdaBusD_ff <= 1'b1;
      end else begin
         sclBusD_ff <= busS[1];
         sdaBusD_ff <= busS[0];
      end
   end
   assign busStart = busS[1] & sclBusD_ff & sdaBusD_ff & ~busS[0];

   // Enable and supply lockout with hysteresis
   always_comb begin
      nxt_run = run_ff;
      if (!enS || uvOffS) begin
         nxt_run = 1'b0;
      end else if (enS && uvOnS) begin
         nxt_run = 1'b1;
      end
   end

   // Charge profile sequencing
   always_comb begin
      nxt_chg = chg_ff;
      unique case (chg_ff)
         CHG_OFF: begin
            if (run_ff && !ovS && !hotS) begin
               nxt_chg = termS ? CHG_CV : CHG_TRACK;
            end
         end
         CHG_TRACK: begin
            if (termS) begin
               nxt_chg = CHG_CV;
            end
         end
         CHG_CV: begin
            if (!termS) begin
               nxt_chg = CHG_TRACK;
            end
         end
         CHG_HOT: begin
            if (coolS) begin
               nxt_chg = CHG_OFF;
            end
         end
      endcase
      if (!run_ff) begin
         nxt_chg = CHG_OFF;
      end else if (hotS) begin
         nxt_chg = CHG_HOT;
      end else if (ovS && chg_ff != CHG_HOT) begin
         nxt_chg = CHG_OFF;
      end
   end

   // Cycle-by-cycle current limit
   always_comb begin
      nxt_pwm = pwm_ff;
      if (chg_ff == CHG_OFF || chg_ff == CHG_HOT) begin
         nxt_pwm = 1'b0;
      end else if (ocS) begin
         nxt_pwm = 1'b0;
      end else if (cycS) begin
         nxt_pwm = 1'b1;
      end
   end

   // Status latching, set wins over read clear
   always_comb begin
      nxt_status = status_ff;
      if (rdStrobe && ptr_ff == REG_STATUS) begin
         nxt_status = STATUS_RST;
      end
      if (ovS) begin
         nxt_status[ST_OV_BIT] = 1'b1;
      end
      if (hotS) begin
         nxt_status[ST_HOT_BIT] = 1'b1;
      end
      if (enS && !run_ff && !uvOnS) begin
         nxt_status[ST_UV_BIT] = 1'b1;
      end
   end

   // Register pointer and writes
   always_comb begin
      nxt_ptr     = ptr_ff;
      nxt_ptrNext = ptrNext_ff;
      nxt_cfg1    = cfg1_ff;
      nxt_cfg3    = cfg3_ff;
      nxt_cfgEn   = cfgEn_ff;
      nxt_eeCtrl  = eeCtrl_ff;
      nxt_rdData  = rdData_ff;
      if (rdStrobe) begin
         nxt_ptr = ptr_ff + 8'h01;
      end
      if (wrStrobe) begin
         if (!ptrNext_ff) begin
            nxt_ptr     = wrData;
            nxt_ptrNext = 1'b1;
         end else begin
            nxt_ptr = ptr_ff + 8'h01;
            unique case (ptr_ff)
               REG_CFG1: begin
                  if (cfgEn_ff[CFG_EN_BIT]) begin
                     nxt_cfg1 = wrData & CFG1_WMASK;
                  end
               end
               REG_CFG3: begin
                  if (cfgEn_ff[CFG_EN_BIT]) begin
                     nxt_cfg3 = wrData & CFG3_WMASK;
                  end
               end
               REG_CFG_EN: begin
                  nxt_cfgEn = wrData & CFG_EN_WMASK;
               end
               REG_EE_CTRL: begin
                  if (cfgEn_ff[CFG_EN_BIT]) begin
                     nxt_eeCtrl = wrData;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (busStart) begin
         nxt_ptrNext = 1'b0;
      end
      unique case (nxt_ptr)
         REG_STATUS:  nxt_rdData = nxt_status;
         REG_CFG1:    nxt_rdData = cfgEn_ff[CFG_EN_BIT] ? cfg1_ff : 8'h00;
         REG_CFG3:    nxt_rdData = cfgEn_ff[CFG_EN_BIT] ? cfg3_ff : 8'h00;
         REG_CFG_EN:  nxt_rdData = cfgEn_ff;
         REG_EE_CTRL: nxt_rdData = cfgEn_ff[CFG_EN_BIT] ? eeCtrl_ff : 8'h00;
         default:     nxt_rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         run_ff     <= 1'b0;
         chg_ff     <= CHG_OFF;
         pwm_ff     <= 1'b0;
         status_ff  <= STATUS_RST;
         cfg1_ff    <= CFG1_RST;
         cfg3_ff    <= CFG3_RST;
         cfgEn_ff   <= CFG_EN_RST;
         eeCtrl_ff  <= EE_CTRL_RST;
         ptr_ff     <= 8'h00;
         ptrNext_ff <= 1'b0;
         rdData_ff  <= 8'h00;
      end else begin
         run_ff     <= nxt_run;
         chg_ff     <= nxt_chg;
         pwm_ff     <= nxt_pwm;
         status_ff  <= nxt_status;
         cfg1_ff    <= nxt_cfg1;
         cfg3_ff    <= nxt_cfg3;
         cfgEn_ff   <= nxt_cfgEn;
         eeCtrl_ff  <= nxt_eeCtrl;
         ptr_ff     <= nxt_ptr;
         ptrNext_ff <= nxt_ptrNext;
         rdData_ff  <= nxt_rdData;
      end
   end

   assign rdData   = rdData_ff;
   assign faultAny = |(status_ff & FAULT_MASK);

   assign fault_out_n_out    = 1'b0;
   assign fault_out_n_oe     = faultAny;
   assign switchOn           = pwm_ff;
   assign switch_node_out_oe = (chg_ff == CHG_TRACK) || (chg_ff == CHG_CV);
   assign max_power_tracking = (chg_ff == CHG_TRACK);
   assign cvRegulate         = (chg_ff == CHG_CV);
   assign running            = run_ff;
   assign termSelect         = cfg1_ff[5:3];
   assign chargeCurrentSel   = cfg3_ff[7:4];
endmodule

/* File: test/charger_i2c_slave_fault_monitor_properties.sv */
`timescale 1ns/1ns
module fault_monitor_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic enablePin,
   input wire logic outAtTerm,
   input wire logic outOverVolt,
   input wire logic overcurrent_threshold,
   input wire logic tempAbove170,
   input wire logic sclIn,
   input wire logic sdaOe,
   input wire logic fault_out_n_oe,
   input wire logic switchOn,
   input wire logic switch_node_out_oe,
   input wire logic max_power_tracking,
   input wire logic cvRegulate,
   input wire logic running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Over-voltage seen while running, then held
   sequence s_ovHeld;
      (running && outOverVolt) ##1 outOverVolt [*3];
   endsequence
   sequence s_hotHeld;
      tempAbove170 [*4];
   endsequence
   property p_ovFault;
      s_ovHeld |-> fault_out_n_oe;
   endproperty
   a_ovFault: assert property (p_ovFault) else $error("no fault on over-voltage");
   property p_ovStop;
      s_ovHeld |-> !max_power_tracking && !cvRegulate;
   endproperty
   a_ovStop: assert property (p_ovStop) else $error("charging kept on over-voltage");
   property p_hotTri;
      s_hotHeld |-> !switch_node_out_oe;
   endproperty
   a_hotTri: assert property (p_hotTri) else $error("switch node driven while hot");
   property p_hotFault;
      s_hotHeld |-> fault_out_n_oe;
   endproperty
   a_hotFault: assert property (p_hotFault) else $error("no fault while hot");
   property p_ocCut;
      overcurrent_threshold [*4] |-> !switchOn;
   endproperty
   a_ocCut: assert property (p_ocCut) else $error("switch on at current limit");
   property p_lockout;
      !enablePin [*4] |-> !running;
   endproperty
   a_lockout: assert property (p_lockout) else $error("running while disabled");
   property p_cvTerm;
      !outAtTerm [*4] |-> !cvRegulate;
   endproperty
   a_cvTerm: assert property (p_cvTerm) else $error("regulating below termination");
   property p_modeExcl;
      !(max_power_tracking && cvRegulate);
   endproperty
   a_modeExcl: assert property (p_modeExcl) else $error("two charge modes at once");
   property p_sdaStable;
      (sclIn && $past(sclIn)) |-> $stable(sdaOe);
   endproperty
   a_sdaStable: assert property (p_sdaStable) else $error("data moved with clock high");
   property p_trackStop;
      (running && outAtTerm) [*4] |-> !max_power_tracking;
   endproperty
   a_trackStop: assert property (p_trackStop) else $error("tracking past termination");
endmodule

bind charger_i2c_slave_fault_monitor fault_monitor_checker fault_monitor_checker_inst (
   .clk(clk), .srst(srst), .enablePin(enablePin), .outAtTerm(outAtTerm),
   .outOverVolt(outOverVolt), .overcurrent_threshold(overcurrent_threshold),
   .tempAbove170(tempAbove170), .sclIn(sclIn), .sdaOe(sdaOe),
   .fault_out_n_oe(fault_out_n_oe), .switchOn(switchOn),
   .switch_node_out_oe(switch_node_out_oe), .max_power_tracking(max_power_tracking),
   .cvRegulate(cvRegulate), .running(running)
);

/* File: test/i2c_master_model.sv */
`timescale 1ns/1ns
module i2c_master_model (
   input  wire logic clk,
   input  wire logic sdaBus,
   output logic      sclOut,
   output logic      sdaLowOut
);
   initial begin
      sclOut = 1'b1;
      sdaLowOut = 1'b0;
   end
   task automatic waitClk(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic startCond();
      waitClk(1);
      sdaLowOut <= 1'b1;
      waitClk(13);
      sclOut <= 1'b0;
   endtask
   // One bit: data set mid-low, sampled mid-high
   task automatic xferBit(input logic b, output logic r);
      waitClk(6);
      sdaLowOut <= ~b;
      waitClk(7);
      sclOut <= 1'b1;
      waitClk(6);
      @(negedge clk);
      r = sdaBus;
      waitClk(7);
      sclOut <= 1'b0;
   endtask
   task automatic byteXfer(input logic [7:0] txd, input logic ackIn,
                           output logic [7:0] rxd, output logic ackOut);
      for (int i = 7; i >= 0; i--) begin
         xferBit(txd[i], rxd[i]);
      end
      xferBit(ackIn, ackOut);
   endtask
   task automatic stopCond();
      waitClk(6);
      sdaLowOut <= 1'b1;
      waitClk(7);
      sclOut <= 1'b1;
      waitClk(7);
      sdaLowOut <= 1'b0;
      waitClk(13);
   endtask
endmodule

/* File: test/charger_i2c_slave_fault_monitor_tb.sv */
`timescale 1ns/1ns
module charger_i2c_slave_fault_monitor_tb
   import charger_pkg::*;
;
   logic       clk, srst, enablePin, supplyAboveOn, supplyBelowOff, outAtTerm;
   logic       outOverVolt, overcurrent_threshold, tempAbove170, tempBelow160;
   logic       cycleStart, sclIn, masterLow, sdaBus, sdaOut, sdaOe;
   logic       fault_out_n_out, fault_out_n_oe, switchOn, switch_node_out_oe;
   logic       max_power_tracking, cvRegulate, running, faultLow, ack;
   logic [2:0] termSelect;
   logic [3:0] chargeCurrentSel;
   logic [7:0] rd;
   int         errorCnt = 0;
   int         testsRun = 0;
   int         n;

   // Open-drain data line with pull-up
   assign sdaBus = ~(masterLow | (sdaOe & ~sdaOut));
   assign faultLow = fault_out_n_oe & ~fault_out_n_out;

   charger_i2c_slave_fault_monitor charger_i2c_slave_fault_monitor_inst (
      .clk(clk), .srst(srst), .enablePin(enablePin), .supplyAboveOn(supplyAboveOn),
      .supplyBelowOff(supplyBelowOff), .outAtTerm(outAtTerm), .outOverVolt(outOverVolt),
      .overcurrent_threshold(overcurrent_threshold), .tempAbove170(tempAbove170),
      .tempBelow160(tempBelow160), .cycleStart(cycleStart), .sclIn(sclIn),
      .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .fault_out_n_out(fault_out_n_out),
      .fault_out_n_oe(fault_out_n_oe), .switchOn(switchOn),
      .switch_node_out_oe(switch_node_out_oe), .max_power_tracking(max_power_tracking),
      .cvRegulate(cvRegulate), .running(running), .termSelect(termSelect),
      .chargeCurrentSel(chargeCurrentSel)
   );
   i2c_master_model i2c_master_model_inst (
      .clk(clk), .sdaBus(sdaBus), .sclOut(sclIn), .sdaLowOut(masterLow)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Switching cycle marker, 1 MHz
   initial begin
      cycleStart = 1'b0;
      forever begin
         repeat (6) @(posedge clk);
         cycleStart <= 1'b1;
         repeat (4) @(posedge clk);
         cycleStart <= 1'b0;
      end
   end

   task automatic chk1(input logic got, input logic exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic doReset();
      @(posedge clk);
      srst <= 1'b1;
      {enablePin, supplyAboveOn, supplyBelowOff, outAtTerm, outOverVolt,
       overcurrent_threshold, tempAbove170, tempBelow160} <= 8'h01;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      settle(3);
   endtask
   task automatic i2cWrite(input logic [7:0] sub, input logic withData, input logic [7:0] d);
      logic [7:0] rx;
      logic       a;
      i2c_master_model_inst.startCond();
      i2c_master_model_inst.byteXfer({DEV_ADDR, 1'b0}, 1'b1, rx, a);
      chk1(a, 1'b0);
      i2c_master_model_inst.byteXfer(sub, 1'b1, rx, a);
      chk1(a, 1'b0);
      if (withData) begin
         i2c_master_model_inst.byteXfer(d, 1'b1, rx, a);
         chk1(a, 1'b0);
      end
      i2c_master_model_inst.stopCond();
   endtask
   task automatic i2cRead(output logic [7:0] d);
      logic a;
      i2c_master_model_inst.startCond();
      i2c_master_model_inst.byteXfer({DEV_ADDR, 1'b1}, 1'b1, d, a);
      chk1(a, 1'b0);
      i2c_master_model_inst.byteXfer(8'hff, 1'b1, d, a);
      i2c_master_model_inst.stopCond();
   endtask
   task automatic endTest(input string name);
      $display("test %s done, mismatches so far %0d", name, errorCnt);
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      errorCnt++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      srst = 1'b1;
      {enablePin, supplyAboveOn, supplyBelowOff, outAtTerm, outOverVolt,
       overcurrent_threshold, tempAbove170, tempBelow160} = 8'h01;
      doReset();
      chk1(faultLow, 1'b0);
      chk1(sdaOe, 1'b0);
      chk1(running, 1'b0);
      chk8({1'b0, termSelect, chargeCurrentSel}, 8'h00);
      endTest("reset");
      @(posedge clk);
      enablePin <= 1'b1;
      settle(8);
      chk1(running, 1'b0);
      chk1(faultLow, 1'b0);
      i2cWrite(REG_STATUS, 1'b0, 8'h00);
      i2cRead(rd);
      chk8(rd, 8'h02);
      @(posedge clk);
      supplyAboveOn <= 1'b1;
      settle(8);
      chk1(running, 1'b1);
      chk1(max_power_tracking, 1'b1);
      @(posedge clk);
      outAtTerm <= 1'b1;
      settle(8);
      chk1(cvRegulate, 1'b1);
      chk1(max_power_tracking, 1'b0);
      @(posedge clk);
      outAtTerm <= 1'b0;
      settle(8);
      chk1(cvRegulate, 1'b0);
      @(posedge clk);
      supplyAboveOn <= 1'b0;
      settle(8);
      chk1(running, 1'b1);
      @(posedge clk);
      supplyBelowOff <= 1'b1;
      settle(8);
      chk1(running, 1'b0);
      endTest("lockout and modes");
      doReset();
      @(posedge clk);
      enablePin <= 1'b1;
      supplyAboveOn <= 1'b1;
      i2cWrite(REG_STATUS, 1'b0, 8'h00);
      @(posedge clk);
      outOverVolt <= 1'b1;
      settle(8);
      chk1(faultLow, 1'b1);
      chk1(max_power_tracking | cvRegulate, 1'b0);
      @(posedge clk);
      outOverVolt <= 1'b0;
      settle(8);
      chk1(faultLow, 1'b1);
      i2cRead(rd);
      chk8(rd, 8'h80);
      settle(3);
      chk1(faultLow, 1'b0);
      endTest("over-voltage");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         tempAbove170 <= 1'b1;
         tempBelow160 <= 1'b0;
         settle(8);
         chk1(switch_node_out_oe, 1'b0);
         chk1(faultLow, 1'b1);
         @(posedge clk);
         tempAbove170 <= 1'b0;
         settle(8);
         chk1(switch_node_out_oe, 1'b0);
         @(posedge clk);
         tempBelow160 <= 1'b1;
         settle(8);
         chk1(switch_node_out_oe, 1'b1);
      end
      endTest("thermal");
      n = 0;
      while (switchOn !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk1(switchOn, 1'b1);
      @(posedge clk);
      overcurrent_threshold <= 1'b1;
      settle(5);
      chk1(switchOn, 1'b0);
      settle(20);
      chk1(switchOn, 1'b0);
      @(posedge clk);
      overcurrent_threshold <= 1'b0;
      endTest("current limit");
      doReset();
      i2c_master_model_inst.startCond();
      i2c_master_model_inst.byteXfer({7'h49, 1'b0}, 1'b1, rd, ack);
      chk1(ack, 1'b1);
      i2c_master_model_inst.stopCond();
      i2cWrite(REG_CFG1, 1'b1, 8'h28);
      settle(4);
      chk8({5'h00, termSelect}, 8'h00);
      i2cWrite(REG_CFG_EN, 1'b1, 8'h01);
      i2cWrite(REG_CFG1, 1'b1, 8'h28);
      i2cWrite(REG_CFG3, 1'b1, 8'h70);
      settle(4);
      chk8({1'b0, termSelect, chargeCurrentSel}, 8'h57);
      i2cWrite(REG_CFG1, 1'b0, 8'h00);
      i2cRead(rd);
      chk8(rd, 8'h28);
      i2cWrite(REG_EE_CTRL, 1'b1, 8'h5a);
      i2cWrite(REG_EE_CTRL, 1'b0, 8'h00);
      i2cRead(rd);
      chk8(rd, 8'h5a);
      endTest("address and locked config");
      summarize();
   end
endmodule
